//--- core/gpio_pwm_port.sv
// general purpose i/o port with twelve pwm channels, axi4-lite registers
`timescale 1ns/100ps
`include "gpio_pwm_defines.svh"
module gpio_pwm_port #(
  parameter int N_PINS = 32,
  parameter int PER_W  = 16
) (
  // clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_resetn,
  // axi4-lite write address and data
  input  wire logic [7:0]        i_awaddr,
  input  wire logic              i_awvalid,
  output logic                   o_awready,
  input  wire logic [31:0]       i_wdata,
  input  wire logic [3:0]        i_wstrb,
  input  wire logic              i_wvalid,
  output logic                   o_wready,
  // axi4-lite write response
  output logic [1:0]             o_bresp,
  output logic                   o_bvalid,
  input  wire logic              i_bready,
  // axi4-lite read
  input  wire logic [7:0]        i_araddr,
  input  wire logic              i_arvalid,
  output logic                   o_arready,
  output logic [31:0]            o_rdata,
  output logic [1:0]             o_rresp,
  output logic                   o_rvalid,
  input  wire logic              i_rready,
  // alternate function on pins above the pwm ones
  input  wire logic [N_PINS-1:0] i_alt_out,
  input  wire logic [N_PINS-1:0] i_alt_oe,
  // pins
  input  wire logic [N_PINS-1:0] i_pin,
  output logic [N_PINS-1:0]      o_pin_out,
  output logic [N_PINS-1:0]      o_pin_oe,
  output logic [N_PINS-1:0]      o_pin_pu
);
  localparam int CH = `GP_PWM_CH;
  localparam int MW = PER_W + `GP_DUTY_W;

  // registers
  logic                    run_r;
  logic [N_PINS-1:0]       dir_r;
  logic [N_PINS-1:0]       out_r;
  logic [N_PINS-1:0]       alt_r;
  logic [PER_W-1:0]        per_r     [2];
  logic [`GP_DUTY_W-1:0]   duty_r    [CH];
  logic [PER_W-1:0]        cnt_r     [2];
  logic [PER_W-1:0]        per_act_r [2];
  logic [N_PINS-1:0]       in_r;

  // write and read path
  gpio_pwm_pkg::wr_state_t wst_r;
  gpio_pwm_pkg::wr_req_t   wreq_r;
  logic                    aw_full_r;
  logic                    w_full_r;
  logic                    awready_r;
  logic                    wready_r;
  logic                    bvalid_r;
  logic [1:0]              bresp_r;
  logic                    arready_r;
  logic                    rvalid_r;
  logic [31:0]             rdata_r;
  logic [1:0]              rresp_r;

  wire aw_hs   = i_awvalid & awready_r;
  wire w_hs    = i_wvalid & wready_r;
  wire aw_have = aw_full_r | aw_hs;
  wire w_have  = w_full_r | w_hs;
  wire do_wr   = (wst_r == gpio_pwm_pkg::WR_IDLE) & aw_have & w_have;
  wire [7:0]  wa     = aw_full_r ? wreq_r.addr : i_awaddr;
  wire [31:0] wd     = w_full_r ? wreq_r.data : i_wdata;
  wire [3:0]  ws     = w_full_r ? wreq_r.strb : i_wstrb;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction : merge

  // address decode, write side
  wire [7:0] wdi       = 8'(wa - `GP_DUTY_BASE);
  wire       w_ctrl    = wa == `GP_CTRL_OFF;
  wire       w_dir     = wa == `GP_DIR_OFF;
  wire       w_out     = wa == `GP_OUT_OFF;
  wire       w_in      = wa == `GP_IN_OFF;
  wire       w_alt     = wa == `GP_ALT_OFF;
  wire       w_per0    = wa == `GP_PER0_OFF;
  wire       w_per1    = wa == `GP_PER1_OFF;
  wire       w_duty    = (wa >= `GP_DUTY_BASE) && (wdi[7:2] < 6'(CH)) && (wa[1:0] == 2'h0);
  wire       w_ok      = w_ctrl | w_dir | w_out | w_in | w_alt | w_per0 | w_per1 | w_duty;
  wire [3:0] w_idx     = wdi[5:2];
  wire [31:0] duty_new = merge(32'(duty_r[w_idx]), wd, ws);

  // address decode, read side
  wire [7:0] rdi    = 8'(i_araddr - `GP_DUTY_BASE);
  wire       r_duty = (i_araddr >= `GP_DUTY_BASE) && (rdi[7:2] < 6'(CH))
                      && (i_araddr[1:0] == 2'h0);
  wire [3:0] r_idx  = rdi[5:2];
  logic [31:0] rd_val;
  logic        rd_ok;

  always_comb begin
    rd_ok  = 1'b1;
    rd_val = 32'h0000_0000;
    if (r_duty) begin
      rd_val = 32'(duty_r[r_idx]);
    end else begin
      case (i_araddr)
        `GP_CTRL_OFF: rd_val = 32'(run_r);
        `GP_DIR_OFF:  rd_val = 32'(dir_r);
        `GP_OUT_OFF:  rd_val = 32'(out_r);
        `GP_IN_OFF:   rd_val = 32'(in_r);
        `GP_ALT_OFF:  rd_val = 32'(alt_r);
        `GP_PER0_OFF: rd_val = 32'(per_r[0]);
        `GP_PER1_OFF: rd_val = 32'(per_r[1]);
        default:      rd_ok  = 1'b0;
      endcase
    end
  end

  // write handshake: address and data taken in either order
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      wst_r     <= gpio_pwm_pkg::WR_IDLE;
      wreq_r    <= '0;
      aw_full_r <= 1'b0;
      w_full_r  <= 1'b0;
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      bvalid_r  <= 1'b0;
      bresp_r   <= `GP_RESP_OKAY;
    end else begin
      case (wst_r)
        gpio_pwm_pkg::WR_IDLE: begin
          if (aw_hs) begin
            wreq_r.addr <= i_awaddr;
            aw_full_r   <= 1'b1;
            awready_r   <= 1'b0;
          end
          if (w_hs) begin
            wreq_r.data <= i_wdata;
            wreq_r.strb <= i_wstrb;
            w_full_r    <= 1'b1;
            wready_r    <= 1'b0;
          end
          if (do_wr) begin
            wst_r     <= gpio_pwm_pkg::WR_RESP;
            awready_r <= 1'b0;
            wready_r  <= 1'b0;
            bvalid_r  <= 1'b1;
            bresp_r   <= w_ok ? `GP_RESP_OKAY : `GP_RESP_SLVERR;
          end
        end
        gpio_pwm_pkg::WR_RESP: begin
          if (i_bready) begin
            wst_r     <= gpio_pwm_pkg::WR_IDLE;
            bvalid_r  <= 1'b0;
            aw_full_r <= 1'b0;
            w_full_r  <= 1'b0;
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
          end
        end
        default: wst_r <= gpio_pwm_pkg::WR_IDLE;
      endcase
    end
  end

  // register writes; the input register is read-only and ignores writes
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      run_r    <= 1'b0;
      dir_r    <= '0;
      out_r    <= '0;
      alt_r    <= '0;
      per_r[0] <= PER_W'(`GP_PER_RST);
      per_r[1] <= PER_W'(`GP_PER_RST);
    end else if (do_wr) begin
      if (w_ctrl) run_r    <= ws[0] ? wd[`GP_CTRL_RUN_BIT] : run_r;
      if (w_dir)  dir_r    <= N_PINS'(merge(32'(dir_r), wd, ws));
      if (w_out)  out_r    <= N_PINS'(merge(32'(out_r), wd, ws));
      if (w_alt)  alt_r    <= N_PINS'(merge(32'(alt_r), wd, ws));
      if (w_per0) per_r[0] <= PER_W'(merge(32'(per_r[0]), wd, ws));
      if (w_per1) per_r[1] <= PER_W'(merge(32'(per_r[1]), wd, ws));
    end
  end

  // duty above full scale is held at full scale
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      for (int k = 0; k < CH; k++) begin
        duty_r[k] <= '0;
      end
    end else if (do_wr && w_duty) begin
      duty_r[w_idx] <= (duty_new > 32'(`GP_DUTY_FULL)) ? `GP_DUTY_FULL
                       : duty_new[`GP_DUTY_W-1:0];
    end
  end

  // read channel: answer one cycle after the address is taken
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= `GP_RESP_OKAY;
    end else if (rvalid_r) begin
      if (i_rready) begin
        rvalid_r  <= 1'b0;
        arready_r <= 1'b1;
      end
    end else if (i_arvalid && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rdata_r   <= rd_val;
      rresp_r   <= rd_ok ? `GP_RESP_OKAY : `GP_RESP_SLVERR;
    end
  end

  // plain sampling of the inverted pin, no filter, so bounce reaches software unfiltered
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      in_r <= '0;
    end else begin
      in_r <= ~i_pin;
    end
  end

  // group period counters; new period taken only at wrap, so no glitch
  logic [PER_W-1:0] per_use [2];
  for (genvar g = 0; g < 2; g++) begin : g_grp
    assign per_use[g] = (per_act_r[g] == '0) ? PER_W'(1) : per_act_r[g];
    wire wrap = cnt_r[g] >= per_use[g] - PER_W'(1);
    always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
        cnt_r[g]     <= '0;
        per_act_r[g] <= PER_W'(`GP_PER_RST);
      end else if (wrap) begin
        cnt_r[g]     <= '0;
        per_act_r[g] <= per_r[g];
      end else begin
        cnt_r[g] <= cnt_r[g] + PER_W'(1);
      end
    end
  end

  // on while cnt/period below duty/100
  logic [CH-1:0] pwm_lvl;
  for (genvar k = 0; k < CH; k++) begin : g_pwm
    localparam int G = k / `GP_PWM_GRP;
    wire [MW-1:0] lhs = MW'(cnt_r[G]) * MW'(`GP_PCT_SCALE);
    wire [MW-1:0] rhs = MW'(duty_r[k]) * MW'(per_use[G]);
    assign pwm_lvl[k] = lhs < rhs;
  end

  // pin drive, every output a flop
  for (genvar p = 0; p < N_PINS; p++) begin : g_pin
    logic drv_out;
    logic drv_oe;
    always_comb begin
      drv_out = 1'b0;
      drv_oe  = 1'b0;
      if (alt_r[p]) begin
        if (p < CH) begin
          drv_out = pwm_lvl[p];
          drv_oe  = 1'b1;
        end else begin
          drv_out = i_alt_out[p];
          drv_oe  = i_alt_oe[p];
        end
      end else if (dir_r[p]) begin
        drv_out = out_r[p];
        drv_oe  = 1'b1;
      end
    end
    always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
        o_pin_out[p] <= 1'b0;
        o_pin_oe[p]  <= 1'b0;
        o_pin_pu[p]  <= 1'b1;
      end else begin
        o_pin_out[p] <= run_r & drv_out;
        o_pin_oe[p]  <= run_r & drv_oe;
        o_pin_pu[p]  <= ~run_r;
      end
    end
  end

  assign o_awready = awready_r;
  assign o_wready  = wready_r;
  assign o_bvalid  = bvalid_r;
  assign o_bresp   = bresp_r;
  assign o_arready = arready_r;
  assign o_rvalid  = rvalid_r;
  assign o_rdata   = rdata_r;
  assign o_rresp   = rresp_r;
endmodule : gpio_pwm_port

//--- common/gpio_pwm_defines.svh
// register map, field positions and reset values of the gpio/pwm port
`ifndef GPIO_PWM_DEFINES_SVH
`define GPIO_PWM_DEFINES_SVH
`define GP_ADDR_W       8
`define GP_CTRL_OFF     8'h00
`define GP_DIR_OFF      8'h04
`define GP_OUT_OFF      8'h08
`define GP_IN_OFF       8'h0C
`define GP_ALT_OFF      8'h10
`define GP_PER0_OFF     8'h14
`define GP_PER1_OFF     8'h18
`define GP_DUTY_BASE    8'h20
`define GP_CTRL_RUN_BIT 0
`define GP_PWM_CH       12
`define GP_PWM_GRP      6
`define GP_DUTY_W       7
`define GP_DUTY_FULL    7'h64
`define GP_PCT_SCALE    7'h64
`define GP_PER_RST      16'h03E8
`define GP_RESP_OKAY    2'h0
`define GP_RESP_SLVERR  2'h2
`endif

//--- common/gpio_pwm_pkg.sv
// types shared by the gpio/pwm port
package gpio_pwm_pkg;
  typedef enum logic [1:0] {
    WR_IDLE = 2'b01,
    WR_RESP = 2'b10
  } wr_state_t;
  typedef struct packed {
    logic [31:0] data;
    logic [3:0]  strb;
    logic [7:0]  addr;
  } wr_req_t;
endpackage : gpio_pwm_pkg

//--- dv/gpio_pwm_port_chk.sv
// bus and pin assertions on the ports of the gpio/pwm block
`timescale 1ns/100ps
module gpio_pwm_port_chk #(
  parameter int N_PINS = 32
) (
  // clock and reset
  input wire logic              i_clk,
  input wire logic              i_resetn,
  // register bus
  input wire logic              i_awvalid,
  input wire logic              o_awready,
  input wire logic              i_wvalid,
  input wire logic              o_wready,
  input wire logic [1:0]        o_bresp,
  input wire logic              o_bvalid,
  input wire logic              i_bready,
  input wire logic              i_arvalid,
  input wire logic              o_arready,
  input wire logic [31:0]       o_rdata,
  input wire logic              o_rvalid,
  input wire logic              i_rready,
  // pins
  input wire logic [N_PINS-1:0] o_pin_oe,
  input wire logic [N_PINS-1:0] o_pin_pu
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  sequence s_wr_take; i_awvalid && o_awready && i_wvalid && o_wready; endsequence
  sequence s_rd_take; i_arvalid && o_arready; endsequence
  sequence s_b_wait; o_bvalid && !i_bready; endsequence
  sequence s_r_wait; o_rvalid && !i_rready; endsequence
  // reset itself is the cause here, so no disable
  chk_reset_pins: assert property (disable iff (1'b0) !i_resetn |=> o_pin_oe == '0 && o_pin_pu == '1)
    else $error("pins not released with pull-up after reset");
  chk_pu_all_none: assert property ((o_pin_pu != '0) |-> (o_pin_pu == '1 && o_pin_oe == '0))
    else $error("pull-up mixed with drive");
  chk_wr_answer: assert property (s_wr_take |=> o_bvalid && !o_awready && !o_wready)
    else $error("write not answered one cycle after take");
  chk_b_stands: assert property (s_b_wait |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped before bready");
  chk_b_release: assert property (o_bvalid && i_bready |=> !o_bvalid && o_awready)
    else $error("write response not released");
  chk_rd_answer: assert property (s_rd_take |=> o_rvalid && !o_arready)
    else $error("read not answered one cycle after take");
  chk_r_stands: assert property (s_r_wait |=> o_rvalid && $stable(o_rdata))
    else $error("read data dropped before rready");
  chk_r_release: assert property (o_rvalid && i_rready |=> !o_rvalid && o_arready)
    else $error("read response not released");
endmodule : gpio_pwm_port_chk

//--- dv/gpio_ext_model.sv
// external drivers, switches and floating lines on the pins
`timescale 1ns/100ps
module gpio_ext_model #(
  parameter int N = 32
) (
  input  wire logic         i_clk,
  input  wire logic [N-1:0] i_out,
  input  wire logic [N-1:0] i_oe,
  input  wire logic [N-1:0] i_pu,
  input  wire logic [N-1:0] i_drv,
  input  wire logic [N-1:0] i_drv_en,
  output logic [N-1:0]      o_level
);
  logic [N-1:0] float_r = '0;
  // undriven line without pull-up toggles so no stale value hides a fault
  always_ff @(posedge i_clk) float_r <= ~float_r;
  assign o_level = (i_oe & i_out) | (~i_oe & i_drv_en & i_drv)
                 | (~i_oe & ~i_drv_en & i_pu)
                 | (~i_oe & ~i_drv_en & ~i_pu & float_r);
endmodule : gpio_ext_model

//--- dv/gpio_pwm_port_tb_top.sv
// self-checking bench for the gpio/pwm block
`timescale 1ns/100ps
`include "gpio_pwm_defines.svh"
module gpio_pwm_port_tb_top;
  logic        i_clk = 1'b0;
  logic        i_resetn = 1'b0;
  logic [7:0]  i_awaddr = '0, i_araddr = '0;
  logic        i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
  logic        i_arvalid = 1'b0, i_rready = 1'b0;
  logic [31:0] i_wdata = '0, o_rdata;
  logic [3:0]  i_wstrb = 4'hF;
  logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [1:0]  o_bresp, o_rresp;
  logic [31:0] i_alt_out = '0, i_alt_oe = '0, i_pin, o_pin_out, o_pin_oe, o_pin_pu;
  logic [31:0] drv = '0, drv_en = '0;
  int          n_mismatch = 0, samples_checked = 0, cyc = 0;
  initial forever #25 i_clk = ~i_clk;
  gpio_pwm_port #(.N_PINS(32), .PER_W(16)) uut (.i_clk, .i_resetn, .i_awaddr, .i_awvalid,
    .o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready,
    .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_alt_out,
    .i_alt_oe, .i_pin, .o_pin_out, .o_pin_oe, .o_pin_pu);
  gpio_ext_model #(.N(32)) u_ext (.i_clk, .i_out(o_pin_out), .i_oe(o_pin_oe),
    .i_pu(o_pin_pu), .i_drv(drv), .i_drv_en(drv_en), .o_level(i_pin));
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // expected response and byte strobes default to a plain full-word write
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = `GP_RESP_OKAY, input logic [3:0] st = 4'hF);
    logic done;
    done = 1'b0;
    @(posedge i_clk);
    i_awaddr <= a;
    i_wdata <= d;
    i_wstrb <= st;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    while (!done) begin
      @(posedge i_clk);
      if (i_awvalid && o_awready) i_awvalid <= 1'b0;
      if (i_wvalid && o_wready) i_wvalid <= 1'b0;
      if (o_bvalid && i_bready) begin
        chk("write resp", o_bresp, er);
        i_bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge i_clk);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    while (!done) begin
      @(posedge i_clk);
      if (i_arvalid && o_arready) i_arvalid <= 1'b0;
      if (o_rvalid && i_rready) begin
        d = o_rdata;
        r = o_rresp;
        i_rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : rd
  function automatic int exp_high(int d, int per);
    int n;
    n = 0;
    if (d > 100) d = 100;
    for (int c = 0; c < per; c++) if (c * 100 < d * per) n++;
    return n;
  endfunction : exp_high
  // whole periods in the window, so the count does not depend on phase
  task automatic measure(input int ch, input int per, input int d);
    int n;
    n = 0;
    repeat (2 * per + 2) @(posedge i_clk);
    repeat (2 * per) begin
      @(posedge i_clk);
      if (o_pin_out[ch] === 1'b1) n++;
    end
    chk("pwm drive", o_pin_oe[ch], 1'b1);
    chk("pwm high count", n, 2 * exp_high(d, per));
  endtask : measure
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  initial begin
    logic [31:0] d, dir, outv;
    logic [1:0]  r;
    int          per [2];
    int          dty [12];
    int          corner [5];
    corner = '{0, 100, 1, 120, 50};
    void'($urandom(55996));
    repeat (12) @(posedge i_clk);
    i_resetn <= 1'b1;
    chk("reset pull-up", o_pin_pu, 32'hFFFF_FFFF);
    chk("reset drive", o_pin_oe, 32'h0000_0000);
    rd(`GP_PER0_OFF, d, r);
    chk("period reset", d, `GP_PER_RST);
    rd(8'hFC, d, r);
    chk("unmapped resp", r, `GP_RESP_SLVERR);
    chk("unmapped data", d, 32'h0000_0000);
    wr(8'hFC, 32'hFFFF_FFFF, `GP_RESP_SLVERR);
    wr(`GP_IN_OFF, 32'hFFFF_FFFF);
    dir = $urandom();
    outv = $urandom();
    // partial strobe: only the middle two bytes may change
    wr(`GP_DIR_OFF, dir);
    wr(`GP_DIR_OFF, ~dir, `GP_RESP_OKAY, 4'h6);
    rd(`GP_DIR_OFF, d, r);
    chk("strobe merge", d, {dir[31:24], ~dir[23:8], dir[7:0]});
    wr(`GP_DIR_OFF, dir);
    wr(`GP_OUT_OFF, outv);
    repeat (2) @(posedge i_clk);
    chk("drive before run", o_pin_oe, 32'h0000_0000);
    chk("pull-up before run", o_pin_pu, 32'hFFFF_FFFF);
    wr(`GP_CTRL_OFF, 32'h0000_0001);
    drv_en <= ~dir;
    for (int i = 0; i < 4; i++) begin
      drv <= $urandom();
      repeat (3) @(posedge i_clk);
      chk("direction", o_pin_oe, dir);
      chk("output level", o_pin_out & dir, outv & dir);
      chk("pull-up after run", o_pin_pu, 32'h0000_0000);
      rd(`GP_IN_OFF, d, r);
      chk("input sense", d, ~((dir & outv) | (~dir & drv)));
    end
    i_alt_out <= $urandom();
    i_alt_oe <= $urandom();
    wr(`GP_ALT_OFF, 32'hFFFF_F000);
    repeat (3) @(posedge i_clk);
    chk("alt drive", o_pin_oe[31:12], i_alt_oe[31:12]);
    chk("alt out", o_pin_out[31:12] & i_alt_oe[31:12],
        i_alt_out[31:12] & i_alt_oe[31:12]);
    per = '{20, 40};
    wr(`GP_PER0_OFF, 32'h0000_0014);
    wr(`GP_PER1_OFF, 32'h0000_0028);
    wr(`GP_ALT_OFF, 32'h0000_0FFF);
    // new periods land only at the next wrap of the reset-length period
    repeat (`GP_PER_RST + 4) @(posedge i_clk);
    for (int k = 0; k < 12; k++) begin
      dty[k] = (k < 5) ? corner[k] : $urandom_range(110);
      wr(`GP_DUTY_BASE + 8'(4 * k), dty[k]);
      rd(`GP_DUTY_BASE + 8'(4 * k), d, r);
      chk("duty stored", d, (dty[k] > 32'(`GP_DUTY_FULL)) ? 32'(`GP_DUTY_FULL)
          : 32'(dty[k]));
      measure(k, per[k / 6], dty[k]);
    end
    wr(`GP_PER0_OFF, 32'h0000_001E);
    measure(4, 30, dty[4]);
    measure(6, 40, dty[6]);
    print_verdict();
  end
endmodule : gpio_pwm_port_tb_top
bind gpio_pwm_port gpio_pwm_port_chk #(.N_PINS(N_PINS)) u_chk (.i_clk, .i_resetn, .i_awvalid,
  .o_awready, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_arvalid, .o_arready,
  .o_rdata, .o_rvalid, .i_rready, .o_pin_oe, .o_pin_pu);
